// [core/packet_sync_pkg.sv]
/*
  Shared constants and types for the packet sync and threshold configuration block.
  Assumes one 250 MHz clock and a host on the serial register port.
*/
package packet_sync_pkg;
    localparam logic [5:0] OFS_FIFO_THRESHOLD = 6'h03;
    localparam logic [5:0] OFS_SYNC_HIGH      = 6'h04;
    localparam logic [5:0] OFS_SYNC_LOW       = 6'h05;
    localparam logic [5:0] OFS_PACKET_LENGTH  = 6'h06;
    localparam logic [5:0] OFS_PACKET_CTRL1   = 6'h07;

    localparam logic [7:0] RST_FIFO_THRESHOLD = 8'h07;
    localparam logic [7:0] RST_SYNC_HIGH      = 8'hD3;
    localparam logic [7:0] RST_SYNC_LOW       = 8'h91;
    localparam logic [7:0] RST_PACKET_LENGTH  = 8'hFF;
    localparam logic [7:0] RST_PACKET_CTRL1   = 8'h04;

    localparam int QUALITY_THR_MSB = 7;
    localparam int QUALITY_THR_LSB = 5;
    localparam int AUTOSYNC_BIT = 4;
    localparam int HDR_READ_BIT = 7;
    localparam int HDR_BURST_BIT = 6;

    localparam logic [6:0] TX_LEVEL_TOP = 7'h3D;
    localparam logic [6:0] RX_LEVEL_STEP = 7'h04;
    localparam logic [4:0] PQ_MAX       = 5'h1F;
    localparam logic [4:0] PQ_DEC       = 5'h04;
    localparam logic [4:0] SYNC_BITS    = 5'h10;
    localparam logic [2:0] LAST_BIT     = 3'h7;

    typedef enum logic [0:0] {PH_HEADER, PH_DATA} spi_phase_e;
endpackage : packet_sync_pkg

// [core/packet_sync_threshold_config.sv]
/*
  Register file, FIFO threshold compare, preamble quality gate, sync word
  detection and packet length check, reached over the serial register port.
  Assumes received bits, FIFO counts and mode inputs come from logic on clock;
  the serial pins come from outside and are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
module packet_sync_threshold_config
    import packet_sync_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        serial_select_n,
    input  wire logic        serial_clock,
    input  wire logic        serial_data_in,
    output var  logic        serial_data_out,
    output var  logic        serial_data_out_en,
    input  wire logic [6:0]  tx_fifo_bytes,
    input  wire logic [6:0]  rx_fifo_bytes,
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_bit,
    input  wire logic        variable_length,
    input  wire logic        wor_active,
    input  wire logic        length_byte_valid,
    input  wire logic [7:0]  length_byte,
    output var  logic        tx_threshold_reached,
    output var  logic        rx_threshold_reached,
    output var  logic [15:0] sync_word,
    output var  logic [7:0]  packet_length_limit,
    output var  logic        sync_detected,
    output var  logic        wor_timer_reset,
    output var  logic        packet_discard,
    output var  logic        packet_accept,
    output var  logic [4:0]  preamble_quality
);
    typedef struct packed {
        logic        sel_m;
        logic        sel_s;
        logic        sck_m;
        logic        sck_s;
        logic        sck_d;
        logic        mosi_m;
        logic        mosi_s;
        spi_phase_e  phase;
        logic [2:0]  bit_cnt;
        logic        is_read;
        logic        burst;
        logic [5:0]  addr;
        logic [7:0]  shift_in;
        logic [7:0]  shift_out;
        logic        miso;
        logic        miso_en;
        logic [7:0]  fifo_level_threshold;
        logic [7:0]  sync_high;
        logic [7:0]  sync_low;
        logic [7:0]  pkt_len;
        logic [7:0]  pkt_ctrl;
        logic [4:0]  pq_cnt;
        logic        prev_bit;
        logic        prev_valid;
        logic [15:0] sync_shift;
        logic [4:0]  sync_fill;
        logic        tx_reached;
        logic        rx_reached;
        logic [15:0] sync_word;
        logic [7:0]  len_limit;
        logic        sync_det;
        logic        wor_reset;
        logic        discard;
        logic        accept;
    } state_s;

    // select idles high so a frame never starts out of reset
    localparam state_s STATE_RESET = '{
        sel_m:                1'b1,
        sel_s:                1'b1,
        phase:                PH_HEADER,
        fifo_level_threshold: RST_FIFO_THRESHOLD,
        sync_high:            RST_SYNC_HIGH,
        sync_low:             RST_SYNC_LOW,
        pkt_len:              RST_PACKET_LENGTH,
        pkt_ctrl:             RST_PACKET_CTRL1,
        sync_word:            {RST_SYNC_HIGH, RST_SYNC_LOW},
        len_limit:            RST_PACKET_LENGTH,
        default:              '0};

    state_s state_reg;
    state_s state_next;

    // unmapped addresses read as zero
    function automatic logic [7:0] read_reg(input state_s s, input logic [5:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == OFS_FIFO_THRESHOLD) begin
            v = s.fifo_level_threshold;
        end else if (a == OFS_SYNC_HIGH) begin
            v = s.sync_high;
        end else if (a == OFS_SYNC_LOW) begin
            v = s.sync_low;
        end else if (a == OFS_PACKET_LENGTH) begin
            v = s.pkt_len;
        end else if (a == OFS_PACKET_CTRL1) begin
            v = s.pkt_ctrl;
        end
        return v;
    endfunction : read_reg

    logic [2:0]  quality_thr;
    logic        pq_ok;
    logic [6:0]  tx_level;
    logic [6:0]  rx_level;
    logic [15:0] sync_candidate;
    logic        sync_hit;
    logic        sck_rise;
    logic        sck_fall;
    logic [7:0]  byte_in;
    logic [5:0]  addr_inc;

    always_comb begin
        quality_thr    = state_reg.pkt_ctrl[QUALITY_THR_MSB:QUALITY_THR_LSB];
        pq_ok          = (quality_thr == 3'h0) || (state_reg.pq_cnt >= {quality_thr, 2'b00});
        tx_level       = TX_LEVEL_TOP - {1'b0, state_reg.fifo_level_threshold[3:0], 2'b00};
        rx_level       = {1'b0, state_reg.fifo_level_threshold[3:0], 2'b00} + RX_LEVEL_STEP;
        sync_candidate = {state_reg.sync_shift[14:0], rx_bit};
        sync_hit       = rx_bit_valid && (state_reg.sync_fill >= SYNC_BITS - 5'h01)
                         && (sync_candidate == {state_reg.sync_high, state_reg.sync_low}) && pq_ok;
        sck_rise       = state_reg.sck_s & ~state_reg.sck_d;
        sck_fall       = ~state_reg.sck_s & state_reg.sck_d;
        byte_in        = {state_reg.shift_in[6:0], state_reg.mosi_s};
        addr_inc       = state_reg.addr + 6'h01;

        state_next        = state_reg;
        state_next.sel_m  = serial_select_n;
        state_next.sel_s  = state_reg.sel_m;
        state_next.sck_m  = serial_clock;
        state_next.sck_s  = state_reg.sck_m;
        state_next.sck_d  = state_reg.sck_s;
        state_next.mosi_m = serial_data_in;
        state_next.mosi_s = state_reg.mosi_m;
        state_next.miso_en = ~state_reg.sel_s;

        // serial port: header byte, then data bytes, msb first, mode 0
        if (state_reg.sel_s) begin
            state_next.phase     = PH_HEADER;
            state_next.bit_cnt   = 3'h0;
            state_next.shift_out = 8'h00;
            state_next.miso      = 1'b0;
        end else if (sck_rise) begin
            state_next.shift_in = byte_in;
            state_next.bit_cnt  = state_reg.bit_cnt + 3'h1;
            if (state_reg.bit_cnt == LAST_BIT) begin
                if (state_reg.phase == PH_HEADER) begin
                    state_next.is_read   = byte_in[HDR_READ_BIT];
                    state_next.burst     = byte_in[HDR_BURST_BIT];
                    state_next.addr      = byte_in[5:0];
                    state_next.phase     = PH_DATA;
                    state_next.shift_out = read_reg(state_reg, byte_in[5:0]);
                end else begin
                    if (!state_reg.is_read) begin
                        if (state_reg.addr == OFS_FIFO_THRESHOLD) begin
                            state_next.fifo_level_threshold = byte_in;
                        end else if (state_reg.addr == OFS_SYNC_HIGH) begin
                            state_next.sync_high = byte_in;
                        end else if (state_reg.addr == OFS_SYNC_LOW) begin
                            state_next.sync_low = byte_in;
                        end else if (state_reg.addr == OFS_PACKET_LENGTH) begin
                            state_next.pkt_len = byte_in;
                        end else if (state_reg.addr == OFS_PACKET_CTRL1) begin
                            state_next.pkt_ctrl = byte_in;
                        end
                    end
                    // single access keeps the address, burst walks it
                    if (state_reg.burst) begin
                        state_next.addr      = addr_inc;
                        state_next.shift_out = read_reg(state_reg, addr_inc);
                    end else begin
                        state_next.shift_out = read_reg(state_reg, state_reg.addr);
                    end
                end
            end
        end else if (sck_fall) begin
            state_next.miso      = state_reg.shift_out[7];
            state_next.shift_out = {state_reg.shift_out[6:0], 1'b0};
        end

        // preamble quality estimator and sync search
        state_next.sync_det  = 1'b0;
        state_next.wor_reset = 1'b0;
        if (rx_bit_valid) begin
            state_next.prev_bit   = rx_bit;
            state_next.prev_valid = 1'b1;
            if (state_reg.prev_valid) begin
                if (rx_bit != state_reg.prev_bit) begin
                    state_next.pq_cnt = (state_reg.pq_cnt == PQ_MAX) ? PQ_MAX
                                                                     : state_reg.pq_cnt + 5'h01;
                end else begin
                    // floor first, the 5-bit subtract would wrap
                    state_next.pq_cnt = (state_reg.pq_cnt < PQ_DEC) ? 5'h00
                                                                    : state_reg.pq_cnt - PQ_DEC;
                end
            end
            state_next.sync_shift = sync_candidate;
            if (state_reg.sync_fill != SYNC_BITS) begin
                state_next.sync_fill = state_reg.sync_fill + 5'h01;
            end
            state_next.sync_det  = sync_hit;
            state_next.wor_reset = sync_hit && state_reg.pkt_ctrl[AUTOSYNC_BIT] && wor_active;
        end

        // the compare gives a verdict in variable length mode only; fixed length gets none
        state_next.len_limit = state_reg.pkt_len;
        state_next.discard   = length_byte_valid && variable_length && (length_byte > state_reg.pkt_len);
        state_next.accept    = length_byte_valid && variable_length && (length_byte <= state_reg.pkt_len);

        state_next.tx_reached = tx_fifo_bytes >= tx_level;
        state_next.rx_reached = rx_fifo_bytes >= rx_level;
        state_next.sync_word  = {state_reg.sync_high, state_reg.sync_low};
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign serial_data_out      = state_reg.miso;
    assign serial_data_out_en   = state_reg.miso_en;
    assign tx_threshold_reached = state_reg.tx_reached;
    assign rx_threshold_reached = state_reg.rx_reached;
    assign sync_word            = state_reg.sync_word;
    assign packet_length_limit  = state_reg.len_limit;
    assign sync_detected        = state_reg.sync_det;
    assign wor_timer_reset      = state_reg.wor_reset;
    assign packet_discard       = state_reg.discard;
    assign packet_accept        = state_reg.accept;
    assign preamble_quality     = state_reg.pq_cnt;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_RX_LEVEL: assert property (
        rx_threshold_reached == $past(rx_fifo_bytes >= 7'(4 * (state_reg.fifo_level_threshold[3:0] + 1))))
        else $error("rx threshold flag wrong");
    AST_TX_LEVEL: assert property (
        tx_threshold_reached == $past(tx_fifo_bytes >= 7'(61 - 4 * state_reg.fifo_level_threshold[3:0])))
        else $error("tx threshold flag wrong");
    AST_SYNC_WORD: assert property (
        ##1 sync_word == $past({state_reg.sync_high, state_reg.sync_low}))
        else $error("sync word not high over low");
    AST_SYNC_MATCH: assert property (
        sync_detected |-> $past(rx_bit_valid && state_reg.sync_fill >= 5'd15
            && {state_reg.sync_shift[14:0], rx_bit} == {state_reg.sync_high, state_reg.sync_low}))
        else $error("sync found without a full match");
    AST_PQ_UP: assert property (
        rx_bit_valid && state_reg.prev_valid && rx_bit != state_reg.prev_bit && preamble_quality < 5'd31
            |=> preamble_quality == $past(preamble_quality) + 5'd1)
        else $error("quality did not rise by one");
    AST_PQ_PRIME: assert property (
        rx_bit_valid && !state_reg.prev_valid |=> preamble_quality == $past(preamble_quality))
        else $error("first bit changed quality");
    AST_PQ_HOLD: assert property (
        !rx_bit_valid |=> $stable(preamble_quality))
        else $error("quality moved without a bit");
    AST_PQ_DOWN: assert property (
        rx_bit_valid && state_reg.prev_valid && rx_bit == state_reg.prev_bit && preamble_quality >= 5'd4
            |=> preamble_quality == $past(preamble_quality) - 5'd4)
        else $error("quality did not fall by four");
    AST_PQ_FLOOR: assert property (
        rx_bit_valid && state_reg.prev_valid && rx_bit == state_reg.prev_bit && preamble_quality < 5'd4
            |=> preamble_quality == 5'd0)
        else $error("quality not held at zero");
    AST_PQ_CEIL: assert property (
        rx_bit_valid && state_reg.prev_valid && rx_bit != state_reg.prev_bit && preamble_quality == 5'd31
            |=> preamble_quality == 5'd31)
        else $error("quality not held at ceiling");
    AST_SYNC_GATE: assert property (
        sync_detected |-> $past(state_reg.pkt_ctrl[7:5] == 3'd0 || preamble_quality >= 5'(4 * state_reg.pkt_ctrl[7:5])))
        else $error("sync accepted below quality threshold");
    AST_WOR_RESET: assert property (
        wor_timer_reset |-> sync_detected && $past(state_reg.pkt_ctrl[4] && wor_active))
        else $error("wake timer reset without cause");
    AST_WOR_QUIET: assert property (
        !(state_reg.pkt_ctrl[4] && wor_active) |=> !wor_timer_reset)
        else $error("wake timer reset while disabled");
    AST_DISCARD: assert property (
        length_byte_valid && variable_length && length_byte > state_reg.pkt_len |=> packet_discard && !packet_accept)
        else $error("oversize packet not discarded");
    AST_ACCEPT: assert property (
        length_byte_valid && variable_length && length_byte <= state_reg.pkt_len |=> packet_accept && !packet_discard)
        else $error("packet within limit not accepted");
    AST_FIXED_QUIET: assert property (
        !(length_byte_valid && variable_length) |=> !packet_accept && !packet_discard)
        else $error("length verdict outside variable mode");
    AST_LENGTH: assert property (
        ##1 packet_length_limit == $past(state_reg.pkt_len))
        else $error("length limit not from register");
endmodule : packet_sync_threshold_config
`default_nettype wire

// [dv/serial_host_model.sv]
/*
  Host model for the serial register port: frames a header byte and one or two data bytes.
  Assumes the device samples the serial pins on clock and syncs them itself.
*/
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
    input  wire logic clock,
    output var  logic serial_select_n,
    output var  logic serial_clock,
    output var  logic serial_data_in,
    input  wire logic serial_data_out,
    input  wire logic serial_data_out_en
);
    // phases well above the 4-cycle minimum, so the 2-flop sync never misses an edge
    localparam int HALF = 6;

    initial begin
        serial_select_n = 1'b1;
        serial_clock    = 1'b0;
        serial_data_in  = 1'b0;
    end

    // one or two data bytes; a single byte travels in the upper half of wdata and rdata
    task automatic xfer(input logic [7:0] hdr, input logic [15:0] wdata, input int nbytes,
                        output logic [15:0] rdata);
        logic [23:0] bits;
        int          lo;
        bits  = {hdr, wdata};
        lo    = 16 - 8 * nbytes;
        rdata = 16'h0000;
        @(posedge clock) serial_select_n <= 1'b0;
        repeat (HALF) @(posedge clock);
        for (int i = 23; i >= lo; i--) begin
            serial_data_in <= bits[i];
            repeat (HALF) @(posedge clock);
            // a released data pin reads low to the host
            if (i < 16) rdata[i] = serial_data_out & serial_data_out_en;
            serial_clock <= 1'b1;
            repeat (HALF) @(posedge clock);
            serial_clock <= 1'b0;
        end
        repeat (HALF) @(posedge clock);
        serial_select_n <= 1'b1;
        // line no longer held: show the inverse so a stale value cannot pass
        serial_data_in  <= ~bits[lo];
        repeat (HALF) @(posedge clock);
    endtask : xfer
endmodule : serial_host_model
`default_nettype wire

// [dv/testbench.sv]
/*
  Self-checking bench for the packet sync and threshold block.
  Assumes the host model drives the serial port and the bench the bit and FIFO inputs.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import packet_sync_pkg::*;
    logic        clock = 1'b0, rst_n = 1'b0;
    logic        serial_select_n, serial_clock, serial_data_in, serial_data_out, serial_data_out_en;
    logic [6:0]  tx_fifo_bytes = 7'h00, rx_fifo_bytes = 7'h00;
    logic        rx_bit_valid = 1'b0, rx_bit = 1'b0, variable_length = 1'b0, wor_active = 1'b0;
    logic        length_byte_valid = 1'b0;
    logic [7:0]  length_byte = 8'h00, packet_length_limit, ctrl = RST_PACKET_CTRL1;
    logic        tx_threshold_reached, rx_threshold_reached, sync_detected, wor_timer_reset;
    logic        packet_discard, packet_accept;
    logic [15:0] sync_word, shift_reg = 16'h0000, exp_sync = 16'hD391;
    logic [4:0]  preamble_quality;
    logic        last_bit = 1'b0;
    int          bad_count = 0, check_count = 0, q = 0, seen = 0;

    always #2 clock = ~clock;

    packet_sync_threshold_config packet_sync_threshold_config_i (.clock, .rst_n, .serial_select_n,
        .serial_clock, .serial_data_in, .serial_data_out, .serial_data_out_en, .tx_fifo_bytes,
        .rx_fifo_bytes, .rx_bit_valid, .rx_bit, .variable_length, .wor_active, .length_byte_valid,
        .length_byte, .tx_threshold_reached, .rx_threshold_reached, .sync_word, .packet_length_limit,
        .sync_detected, .wor_timer_reset, .packet_discard, .packet_accept, .preamble_quality);
    serial_host_model serial_host_model_i (.clock, .serial_select_n, .serial_clock, .serial_data_in,
        .serial_data_out, .serial_data_out_en);

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] r;
        serial_host_model_i.xfer({2'b00, a}, {d, 8'h00}, 1, r);
    endtask : wr

    task automatic rd_check(input logic [5:0] a, input logic [7:0] e);
        logic [15:0] r;
        serial_host_model_i.xfer({2'b10, a}, 16'h0000, 1, r);
        check(16'(r[15:8]), 16'(e), "register read");
    endtask : rd_check

    // reference counter and matcher; the gate uses the count before the closing bit
    task automatic send_bit(input logic b);
        logic hit;
        hit = ({shift_reg[14:0], b} == exp_sync) && seen >= 15
              && (ctrl[7:5] == 3'h0 || q >= 4 * ctrl[7:5]);
        if (seen > 0) q = (b != last_bit) ? ((q < 31) ? q + 1 : 31) : ((q > 4) ? q - 4 : 0);
        last_bit  = b;
        shift_reg = {shift_reg[14:0], b};
        seen++;
        @(posedge clock);
        rx_bit_valid <= 1'b1;
        rx_bit       <= b;
        @(posedge clock) rx_bit_valid <= 1'b0;
        @(negedge clock);
        check(16'(preamble_quality), 16'(q), "quality");
        check(16'(sync_detected), 16'(hit), "sync found");
        check(16'(wor_timer_reset), 16'(hit && ctrl[AUTOSYNC_BIT] && wor_active), "wake reset");
    endtask : send_bit

    task automatic send_word(input logic [63:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) send_bit(w[i]);
    endtask : send_word

    task automatic test_reset_values();
        rd_check(OFS_FIFO_THRESHOLD, 8'h07);
        rd_check(OFS_SYNC_HIGH, 8'hD3);
        rd_check(OFS_SYNC_LOW, 8'h91);
        rd_check(OFS_PACKET_LENGTH, 8'hFF);
        rd_check(OFS_PACKET_CTRL1, RST_PACKET_CTRL1);
        wr(6'h3F, 8'hFF);
        rd_check(6'h3F, 8'h00);
        check(sync_word, 16'hD391, "sync word");
    endtask : test_reset_values

    task automatic test_thresholds();
        for (int n = 0; n < 16; n++) begin
            wr(OFS_FIFO_THRESHOLD, {4'h0, 4'(n)});
            for (int d = 0; d < 2; d++) begin
                @(posedge clock);
                tx_fifo_bytes <= 7'(61 - 4 * n - d);
                rx_fifo_bytes <= 7'(4 * (n + 1) - d);
                @(posedge clock);
                @(negedge clock);
                check(16'(tx_threshold_reached), 16'(d == 0), "tx level");
                check(16'(rx_threshold_reached), 16'(d == 0), "rx level");
            end
        end
    endtask : test_thresholds

    task automatic test_sync();
        logic [15:0] r;
        serial_host_model_i.xfer({2'b01, OFS_SYNC_HIGH}, 16'hA53C, 2, r);
        exp_sync = 16'hA53C;
        check(sync_word, exp_sync, "sync word");
        rd_check(OFS_SYNC_HIGH, 8'hA5);
        serial_host_model_i.xfer({2'b11, OFS_SYNC_HIGH}, 16'h0000, 2, r);
        check(r, 16'hA53C, "burst read");
        ctrl = 8'h10;
        wr(OFS_PACKET_CTRL1, ctrl);
        @(posedge clock) wor_active <= 1'b1;
        send_word(64'h00, 8);
        send_word(64'hA53C, 16);
        ctrl = 8'h50;
        wr(OFS_PACKET_CTRL1, ctrl);
        @(posedge clock) wor_active <= 1'b0;
        send_word(64'hA53C, 16);
        send_word(64'hAAAA_AAAA_AA, 40);
        send_word(64'hA53C, 16);
        ctrl = 8'h00;
        wr(OFS_PACKET_CTRL1, ctrl);
        @(posedge clock) wor_active <= 1'b1;
        send_word(64'hA53C, 16);
    endtask : test_sync

    task automatic test_length();
        logic [9:0] cases [4] = '{10'h240, 10'h241, 10'h041, 10'h200};
        wr(OFS_PACKET_LENGTH, 8'h40);
        check(16'(packet_length_limit), 16'h0040, "length limit");
        foreach (cases[i]) begin
            @(posedge clock);
            variable_length   <= cases[i][9];
            length_byte       <= cases[i][7:0];
            length_byte_valid <= 1'b1;
            @(posedge clock) length_byte_valid <= 1'b0;
            @(negedge clock);
            check(16'({packet_accept, packet_discard}),
                  16'(cases[i][9] ? (cases[i][7:0] > 8'h40 ? 2'b01 : 2'b10) : 2'b00), "length verdict");
        end
    endtask : test_length

    task automatic report_and_stop();
        if (bad_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        test_reset_values();
        test_thresholds();
        test_sync();
        test_length();
        report_and_stop();
    end

    // about 7k cycles of traffic expected
    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
